// file: inc/status_pkg.sv
// Shared constants for the status reporting block: register map, widths, preset values.
// Assumes a single 200 MHz clock domain and the plain address/strobe register port.
package status_pkg;

    // ****************************************************************
    // Register map (byte addresses, one word each)
    // ****************************************************************
    localparam logic [7:0] ADDR_ACT_LIVE = 8'h00;
    localparam logic [7:0] ADDR_ACT_EVENT = 8'h04;
    localparam logic [7:0] ADDR_ACT_MASK = 8'h08;
    localparam logic [7:0] ADDR_ACT_RISE = 8'h0C;
    localparam logic [7:0] ADDR_ACT_FALL = 8'h10;
    localparam logic [7:0] ADDR_DBT_LIVE = 8'h14;
    localparam logic [7:0] ADDR_DBT_EVENT = 8'h18;
    localparam logic [7:0] ADDR_DBT_MASK = 8'h1C;
    localparam logic [7:0] ADDR_DBT_RISE = 8'h20;
    localparam logic [7:0] ADDR_DBT_FALL = 8'h24;
    localparam logic [7:0] ADDR_PRESET = 8'h28;
    localparam logic [7:0] ADDR_ERR_NEXT = 8'h2C;
    localparam logic [7:0] ADDR_ERR_PUSH = 8'h30;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h34;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h38;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h3C;

    // ****************************************************************
    // Fields and values
    // ****************************************************************
    localparam int GROUP_W = 16;
    localparam int ERR_W = 16;
    localparam logic [15:0] RISE_PRESET = 16'hFFFF;
    localparam logic [15:0] FALL_PRESET = 16'h0000;
    localparam logic [15:0] MASK_PRESET = 16'h0000;
    localparam logic [15:0] GROUP_RESET = 16'h0000;
    localparam logic [15:0] NO_ERROR_CODE = 16'h0000;
    localparam int ERR_EMPTY_BIT = 16;
    localparam int IRQ_ACT_BIT = 0;
    localparam int IRQ_DBT_BIT = 1;
    localparam int IRQ_ERR_BIT = 2;
    localparam int IRQ_OVF_BIT = 3;
    localparam int IRQ_W = 4;
    localparam int ERR_DEPTH = 8;

endpackage

// file: hdl/error_queue.sv
// First-in first-out store of signed error codes, flip-flop based.
// Assumes push and pop come from logic on the same clock; a push into a full queue is dropped.
`timescale 1ns/1ps
module error_queue import status_pkg::*; #(
    parameter int DEPTH = ERR_DEPTH,
    parameter int WIDTH = ERR_W
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_push,
    input wire logic signed [WIDTH-1:0] i_code,
    input wire logic i_pop,
    output logic signed [WIDTH-1:0] o_head,
    output logic o_empty,
    output logic o_full
);
    localparam int AW = $clog2(DEPTH);

    logic signed [WIDTH-1:0] mem_q [DEPTH];
    logic signed [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [AW:0] cnt_q, cnt_d;
    logic do_push, do_pop;

    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            return '0;
        end
        return p + 1'b1;
    endfunction

    assign o_empty = (cnt_q == '0);
    assign o_full = (cnt_q == (AW+1)'(DEPTH));
    // Oldest entry leaves first; an empty queue shows code zero.
    assign o_head = o_empty ? $signed(NO_ERROR_CODE) : mem_q[rd_q];

    always_comb begin
        do_push = i_push && !o_full;
        do_pop = i_pop && !o_empty;
        mem_d = mem_q;
        rd_d = rd_q;
        wr_d = wr_q;
        cnt_d = cnt_q;
        if (do_push) begin
            mem_d[wr_q] = i_code;
            wr_d = inc(wr_q);
        end
        if (do_pop) begin
            rd_d = inc(rd_q);
        end
        if (do_push && !do_pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (do_pop && !do_push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rd_q <= '0;
            wr_q <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end
endmodule

// file: hdl/status_reporting_registers.sv
// Status reporting block: activity and doubtful_status_group with live, filter,
// latched event and mask parts, summary bits, error queue and an interrupt.
// Assumes status inputs come from outside the clock domain and are synchronised here;
// error pushes and the instrument reset pulse come from logic on the same clock.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module status_reporting_registers import status_pkg::*; #(
    parameter int GW = GROUP_W,
    parameter int DEPTH = ERR_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [GW-1:0] i_act_status,
    input wire logic [GW-1:0] i_dbt_status,
    input wire logic i_err_push,
    input wire logic signed [ERR_W-1:0] i_err_code,
    input wire logic i_inst_reset,
    output logic [31:0] o_rdata,
    output logic o_act_summary,
    output logic o_dbt_summary,
    output logic o_irq
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [GW-1:0] act_s1_q, act_live_q, dbt_s1_q, dbt_live_q;
    logic [GW-1:0] act_prev_q, dbt_prev_q;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            act_s1_q <= GROUP_RESET;
            act_live_q <= GROUP_RESET;
            dbt_s1_q <= GROUP_RESET;
            dbt_live_q <= GROUP_RESET;
            act_prev_q <= GROUP_RESET;
            dbt_prev_q <= GROUP_RESET;
        end else begin
            act_s1_q <= i_act_status;
            act_live_q <= act_s1_q;
            dbt_s1_q <= i_dbt_status;
            dbt_live_q <= dbt_s1_q;
            act_prev_q <= act_live_q;
            dbt_prev_q <= dbt_live_q;
        end
    end

    // ****************************************************************
    // Register file and event latching
    // ****************************************************************
    logic [GW-1:0] act_evt_q, act_evt_d, dbt_evt_q, dbt_evt_d;
    logic [GW-1:0] act_mask_q, act_mask_d, dbt_mask_q, dbt_mask_d;
    logic [GW-1:0] act_rise_q, act_rise_d, dbt_rise_q, dbt_rise_d;
    logic [GW-1:0] act_fall_q, act_fall_d, dbt_fall_q, dbt_fall_d;
    logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_en_q, irq_en_d;
    logic [31:0] rdata_d;
    logic act_sum_d, dbt_sum_d, irq_d, ovf_d;
    logic wr_at_preset, err_pop;
    logic signed [ERR_W-1:0] err_head;
    logic err_empty, err_full;

    function automatic logic [GW-1:0] edges(input logic [GW-1:0] prev, input logic [GW-1:0] cur,
                                            input logic [GW-1:0] rise, input logic [GW-1:0] fall);
        return (~prev & cur & rise) | (prev & ~cur & fall);
    endfunction

    function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] ref_a);
        return strobe && (a == ref_a);
    endfunction

    assign wr_at_preset = hit(i_wr, i_addr, ADDR_PRESET);
    assign err_pop = hit(i_rd, i_addr, ADDR_ERR_NEXT);

    error_queue #(.DEPTH(DEPTH), .WIDTH(ERR_W)) u_errq (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_push(i_err_push),
        .i_code(i_err_code),
        .i_pop(err_pop),
        .o_head(err_head),
        .o_empty(err_empty),
        .o_full(err_full)
    );

    always_comb begin
        act_mask_d = act_mask_q;
        dbt_mask_d = dbt_mask_q;
        act_rise_d = act_rise_q;
        dbt_rise_d = dbt_rise_q;
        act_fall_d = act_fall_q;
        dbt_fall_d = dbt_fall_q;
        irq_en_d = irq_en_q;
        // The instrument reset pulse is deliberately not read here.
        if (i_wr) begin
            unique case (i_addr)
                ADDR_ACT_MASK: act_mask_d = i_wdata[GW-1:0];
                ADDR_DBT_MASK: dbt_mask_d = i_wdata[GW-1:0];
                ADDR_ACT_RISE: act_rise_d = i_wdata[GW-1:0];
                ADDR_DBT_RISE: dbt_rise_d = i_wdata[GW-1:0];
                ADDR_ACT_FALL: act_fall_d = i_wdata[GW-1:0];
                ADDR_DBT_FALL: dbt_fall_d = i_wdata[GW-1:0];
                ADDR_IRQ_ENABLE: irq_en_d = i_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
        if (wr_at_preset) begin
            act_rise_d = RISE_PRESET;
            dbt_rise_d = RISE_PRESET;
            act_fall_d = FALL_PRESET;
            dbt_fall_d = FALL_PRESET;
            act_mask_d = MASK_PRESET;
            dbt_mask_d = MASK_PRESET;
        end
    end

    always_comb begin
        act_evt_d = act_evt_q;
        dbt_evt_d = dbt_evt_q;
        if (hit(i_rd, i_addr, ADDR_ACT_EVENT)) begin
            act_evt_d = GROUP_RESET;
        end
        if (hit(i_rd, i_addr, ADDR_DBT_EVENT)) begin
            dbt_evt_d = GROUP_RESET;
        end
        // New edges are ORed in after the clear so an edge in the read cycle survives.
        act_evt_d = act_evt_d | edges(act_prev_q, act_live_q, act_rise_q, act_fall_q);
        dbt_evt_d = dbt_evt_d | edges(dbt_prev_q, dbt_live_q, dbt_rise_q, dbt_fall_q);
        act_sum_d = |(act_evt_d & act_mask_d);
        dbt_sum_d = |(dbt_evt_d & dbt_mask_d);
        ovf_d = i_err_push && err_full;
        irq_st_d = irq_st_q;
        if (hit(i_wr, i_addr, ADDR_IRQ_CLEAR)) begin
            irq_st_d = irq_st_q & ~i_wdata[IRQ_W-1:0];
        end
        irq_st_d[IRQ_ACT_BIT] = irq_st_d[IRQ_ACT_BIT] | act_sum_d;
        irq_st_d[IRQ_DBT_BIT] = irq_st_d[IRQ_DBT_BIT] | dbt_sum_d;
        irq_st_d[IRQ_ERR_BIT] = irq_st_d[IRQ_ERR_BIT] | i_err_push;
        irq_st_d[IRQ_OVF_BIT] = irq_st_d[IRQ_OVF_BIT] | ovf_d;
        irq_d = |(irq_st_d & irq_en_d);
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_ACT_LIVE: rdata_d[GW-1:0] = act_live_q;
                ADDR_DBT_LIVE: rdata_d[GW-1:0] = dbt_live_q;
                ADDR_ACT_EVENT: rdata_d[GW-1:0] = act_evt_q;
                ADDR_DBT_EVENT: rdata_d[GW-1:0] = dbt_evt_q;
                ADDR_ACT_MASK: rdata_d[GW-1:0] = act_mask_q;
                ADDR_DBT_MASK: rdata_d[GW-1:0] = dbt_mask_q;
                ADDR_ACT_RISE: rdata_d[GW-1:0] = act_rise_q;
                ADDR_DBT_RISE: rdata_d[GW-1:0] = dbt_rise_q;
                ADDR_ACT_FALL: rdata_d[GW-1:0] = act_fall_q;
                ADDR_DBT_FALL: rdata_d[GW-1:0] = dbt_fall_q;
                ADDR_ERR_NEXT: begin
                    rdata_d[ERR_W-1:0] = err_head;
                    rdata_d[ERR_EMPTY_BIT] = err_empty;
                end
                ADDR_IRQ_STATUS: rdata_d[IRQ_W-1:0] = irq_st_q;
                ADDR_IRQ_ENABLE: rdata_d[IRQ_W-1:0] = irq_en_q;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            act_evt_q <= GROUP_RESET;
            dbt_evt_q <= GROUP_RESET;
            act_mask_q <= MASK_PRESET;
            dbt_mask_q <= MASK_PRESET;
            act_rise_q <= RISE_PRESET;
            dbt_rise_q <= RISE_PRESET;
            act_fall_q <= FALL_PRESET;
            dbt_fall_q <= FALL_PRESET;
            irq_st_q <= '0;
            irq_en_q <= '0;
            o_rdata <= 32'h0000_0000;
            o_act_summary <= 1'b0;
            o_dbt_summary <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            act_evt_q <= act_evt_d;
            dbt_evt_q <= dbt_evt_d;
            act_mask_q <= act_mask_d;
            dbt_mask_q <= dbt_mask_d;
            act_rise_q <= act_rise_d;
            dbt_rise_q <= dbt_rise_d;
            act_fall_q <= act_fall_d;
            dbt_fall_q <= dbt_fall_d;
            irq_st_q <= irq_st_d;
            irq_en_q <= irq_en_d;
            o_rdata <= rdata_d;
            o_act_summary <= act_sum_d;
            o_dbt_summary <= dbt_sum_d;
            o_irq <= irq_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_evt_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == ADDR_ACT_EVENT) |=>
            (act_evt_q == edges($past(act_prev_q), $past(act_live_q),
                                $past(act_rise_q), $past(act_fall_q)));
    endproperty
    a_evt_clear: assert property (p_evt_clear) else $error("event part not cleared by read");

    property p_live_read;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == ADDR_DBT_LIVE) |=> (o_rdata[GW-1:0] == $past(dbt_live_q));
    endproperty
    a_live_read: assert property (p_live_read) else $error("live read wrong");

    property p_live_keep;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == ADDR_ACT_LIVE) |=> (act_live_q == $past(act_s1_q)
            && (act_evt_q & $past(act_evt_q)) == $past(act_evt_q));
    endproperty
    a_live_keep: assert property (p_live_keep) else $error("live read had a side effect");

    property p_live_sync;
        @(posedge i_clk) disable iff (!i_rst_n)
        ##2 (act_live_q == $past(i_act_status, 2));
    endproperty
    a_live_sync: assert property (p_live_sync) else $error("live part not two-stage");

    property p_mask_gate;
        @(posedge i_clk) disable iff (!i_rst_n)
        (o_act_summary == |(act_evt_q & act_mask_q))
            && (o_dbt_summary == |(dbt_evt_q & dbt_mask_q));
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("summary not masked");

    property p_rise_latch;
        @(posedge i_clk) disable iff (!i_rst_n)
        (|(~act_prev_q & act_live_q & act_rise_q)) |=>
            ((act_evt_q & $past(~act_prev_q & act_live_q & act_rise_q)) != '0);
    endproperty
    a_rise_latch: assert property (p_rise_latch) else $error("rise edge lost");

    property p_fall_latch;
        @(posedge i_clk) disable iff (!i_rst_n)
        (|(dbt_prev_q & ~dbt_live_q & dbt_fall_q)) |=>
            ((dbt_evt_q & $past(dbt_prev_q & ~dbt_live_q & dbt_fall_q)) != '0);
    endproperty
    a_fall_latch: assert property (p_fall_latch) else $error("fall edge lost");

    property p_preset;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_wr && i_addr == ADDR_PRESET) |=> (act_rise_q == RISE_PRESET && dbt_rise_q == RISE_PRESET
            && act_fall_q == FALL_PRESET && dbt_fall_q == FALL_PRESET
            && act_mask_q == MASK_PRESET && dbt_mask_q == MASK_PRESET);
    endproperty
    a_preset: assert property (p_preset) else $error("preset values wrong");

    property p_inst_reset;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_inst_reset && !i_wr) |=> ($stable(act_mask_q) && $stable(dbt_rise_q)
            && $stable(act_fall_q));
    endproperty
    a_inst_reset: assert property (p_inst_reset) else $error("inst reset touched status");

    property p_err_empty;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == ADDR_ERR_NEXT && err_empty) |=>
            (o_rdata[ERR_W-1:0] == NO_ERROR_CODE && o_rdata[ERR_EMPTY_BIT]);
    endproperty
    a_err_empty: assert property (p_err_empty) else $error("empty queue read wrong");

    property p_err_head;
        @(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == ADDR_ERR_NEXT && !err_empty) |=>
            (o_rdata[ERR_W-1:0] == $past(err_head) && !o_rdata[ERR_EMPTY_BIT]);
    endproperty
    a_err_head: assert property (p_err_head) else $error("queue head read wrong");

    c_preset: cover property (@(posedge i_clk) disable iff (!i_rst_n) wr_at_preset);
    c_evt_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_rd && i_addr == ADDR_ACT_EVENT && act_evt_q != '0));
    c_err_pop: cover property (@(posedge i_clk) disable iff (!i_rst_n) (err_pop && !err_empty));
    c_irq: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_irq);
    c_err_ovf: cover property (@(posedge i_clk) disable iff (!i_rst_n) (i_err_push && err_full));
endmodule

// file: test/status_host.sv
// Register bus master standing in for the remote controller of the status block.
// Assumes the plain strobe port: read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module status_host (
    input wire logic i_clk,
    input wire logic [31:0] i_rdata,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
    endtask

    // Read data stand one cycle after the strobe; they are taken at the edge that ends it.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        @(posedge i_clk);
        d = i_rdata;
    endtask
endmodule

// file: test/tb_status_reporting_registers.sv
// Self-checking bench for the status block, with a behavioural model of groups and queue.
// Assumes the host model drives the register port and this module drives all other inputs.
`timescale 1ns/1ps
module tb_status_reporting_registers import status_pkg::*;;
    logic i_clk;
    logic i_rst_n;
    logic i_err_push;
    logic i_inst_reset;
    logic signed [15:0] i_err_code;
    logic [15:0] st [2];
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic wr;
    logic rd;
    logic act_sum;
    logic dbt_sum;
    logic irq;
    int err_count;
    int n_tests;
    logic [15:0] ev [2];
    logic [15:0] rise_m [2];
    logic [15:0] fall_m [2];
    logic [15:0] mask_m [2];
    logic [15:0] prv [2];
    int q [$];

    status_host host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_wr(wr), .o_rd(rd));

    status_reporting_registers #(.GW(16), .DEPTH(ERR_DEPTH)) uut (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .i_act_status(st[0]), .i_dbt_status(st[1]), .i_err_push(i_err_push),
        .i_err_code(i_err_code), .i_inst_reset(i_inst_reset), .o_rdata(rdata),
        .o_act_summary(act_sum), .o_dbt_summary(dbt_sum), .o_irq(irq));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask

    // The model records the edge at once; five cycles cover the two sync stages and the latch.
    task automatic apply(input int g, input logic [15:0] s);
        @(posedge i_clk);
        st[g] <= s;
        ev[g] = ev[g] | (~prv[g] & s & rise_m[g]) | (prv[g] & ~s & fall_m[g]);
        prv[g] = s;
        repeat (5) @(posedge i_clk);
    endtask

    task automatic preset_chk();
        logic [7:0] b;
        for (int g = 0; g < 2; g++) begin
            b = (g == 0) ? ADDR_ACT_LIVE : ADDR_DBT_LIVE;
            rise_m[g] = 16'hFFFF;
            fall_m[g] = 16'h0000;
            mask_m[g] = 16'h0000;
            rdc(b + 8'h0C, 32'h0000_FFFF);
            rdc(b + 8'h10, 32'h0000_0000);
            rdc(b + 8'h08, 32'h0000_0000);
            rdc(b + 8'h04, {16'h0000, ev[g]});
        end
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    initial begin
        #400000;
        err_count++;
        final_report();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] b;
        logic signed [15:0] c;
        i_rst_n = 1'b0;
        st[0] = 16'h0000;
        st[1] = 16'h0000;
        i_err_push = 1'b0;
        i_err_code = 16'sh0000;
        i_inst_reset = 1'b0;
        err_count = 0;
        n_tests = 0;
        for (int g = 0; g < 2; g++) begin
            ev[g] = 16'h0000;
            prv[g] = 16'h0000;
        end
        void'($urandom(21));
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        preset_chk();
        rdc(ADDR_ERR_NEXT, 32'h0001_0000);
        rdc(ADDR_ERR_PUSH, 32'h0000_0000);
        $display("test reset values done");

        for (int g = 0; g < 2; g++) begin
            b = (g == 0) ? ADDR_ACT_LIVE : ADDR_DBT_LIVE;
            for (int i = 0; i < 6; i++) begin
                rise_m[g] = 16'($urandom);
                fall_m[g] = 16'($urandom);
                mask_m[g] = (i == 0) ? 16'hFFFF : 16'($urandom);
                host.wr(b + 8'h0C, {16'h0000, rise_m[g]});
                host.wr(b + 8'h10, {16'h0000, fall_m[g]});
                host.wr(b + 8'h08, {16'h0000, mask_m[g]});
                apply(g, 16'($urandom));
                chk({31'h0, (g == 0) ? act_sum : dbt_sum}, {31'h0, |(ev[g] & mask_m[g])});
                host.wr(b, 32'h0000_FFFF);
                @(posedge i_clk);
                i_inst_reset <= 1'b1;
                @(posedge i_clk);
                i_inst_reset <= 1'b0;
                rdc(b, {16'h0000, st[g]});
                rdc(b, {16'h0000, st[g]});
                rdc(b + 8'h0C, {16'h0000, rise_m[g]});
                rdc(b + 8'h10, {16'h0000, fall_m[g]});
                rdc(b + 8'h08, {16'h0000, mask_m[g]});
                rdc(b + 8'h04, {16'h0000, ev[g]});
                ev[g] = 16'h0000;
                rdc(b + 8'h04, 32'h0000_0000);
                chk({31'h0, (g == 0) ? act_sum : dbt_sum}, 32'h0000_0000);
            end
        end
        $display("test groups done");

        host.wr(ADDR_PRESET, $urandom);
        preset_chk();
        $display("test preset done");

        // Summaries are masked off now, so the sticky summary bits of the irq status can clear.
        host.wr(ADDR_IRQ_CLEAR, 32'h0000_000F);
        host.wr(ADDR_IRQ_ENABLE, 32'h0000_0004);
        rdc(ADDR_IRQ_ENABLE, 32'h0000_0004);
        rdc(ADDR_IRQ_STATUS, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        for (int i = 0; i <= ERR_DEPTH; i++) begin
            c = 16'($urandom);
            c[15] = i[0];
            i_err_push <= 1'b1;
            i_err_code <= c;
            if (q.size() < ERR_DEPTH) begin
                q.push_back(int'(c));
            end
            @(posedge i_clk);
        end
        i_err_push <= 1'b0;
        repeat (2) @(posedge i_clk);
        rdc(ADDR_IRQ_STATUS, 32'h0000_000C);
        chk({31'h0, irq}, 32'h0000_0001);
        host.wr(ADDR_IRQ_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge i_clk);
        chk({31'h0, irq}, 32'h0000_0000);
        host.wr(ADDR_IRQ_CLEAR, 32'h0000_0004);
        rdc(ADDR_IRQ_STATUS, 32'h0000_0008);
        while (q.size() > 0) begin
            rdc(ADDR_ERR_NEXT, {16'h0000, 16'(q.pop_front())});
        end
        rdc(ADDR_ERR_NEXT, 32'h0001_0000);
        $display("test error queue and interrupt done");
        final_report();
    end
endmodule
